//--- core/sop_pkg.sv
// Shared constants for the output-two sum-of-products sequencing block.
// Assumes an 8-bit internal configuration register file loaded by the serial port.
package sop_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OUT2_PRIMARY_WDOG_SELECT_ADDR    = 8'h12;
  localparam logic [7:0] OUT2_SECONDARY_INPUT_SELECT_ADDR = 8'h13;
  localparam logic [7:0] OUT2_INPUT_OUTPUT_SELECT_ADDR    = 8'h14;
  localparam logic [7:0] OUT2_LAST_OUTPUT_AND_STAGE_ADDR  = 8'h15;
  localparam logic [7:0] OUTPUT_POLARITY_ADDR             = 8'h3A;
  localparam logic [7:0] MANUAL_RESET_OUTPUT_MAP_ADDR     = 8'h40;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         OUT8_DEP_BIT   = 0;
  localparam int         STAGE_LSB      = 1;
  localparam int         STAGE_W        = 4;
  localparam int         TMO_LSB        = 5;
  localparam int         TMO_W          = 3;
  localparam int         OUT2_MAP_BIT   = 1;
  localparam int         OUT2_POL_BIT   = 1;
  localparam int         TERM_W         = 25;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ  = 125;
  localparam int unsigned TMO_N    = 8;
  localparam int unsigned TMO_US [TMO_N] = '{25, 1500, 2500, 6000, 50000, 200000, 400000,
                                             1600000};

  function automatic logic [31:0] sop_us_to_cyc(input int unsigned us);
    sop_us_to_cyc = 32'(us * CLK_MHZ);
  endfunction

endpackage

//--- core/sop_deassert_timer.sv
// Deassertion delay for one programmable output.
// Assumes i_hold is registered and i_tmo_cyc is at least one.
`timescale 1ns/1ps
module sop_deassert_timer
  import sop_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_hold,
  input  wire logic [31:0] i_tmo_cyc,
  output logic             o_asserted
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        asserted_nxt;
  wire         expire = (cnt_r >= i_tmo_cyc - 32'h0000_0001);

  // Assert at once, release only after the timeout runs out uninterrupted
  assign asserted_nxt = i_hold ? 1'b1 : (o_asserted & ~expire);
  assign cnt_nxt      = (i_hold | ~o_asserted) ? 32'h0000_0000 : cnt_r + 32'h0000_0001;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_asserted <= 1'b1;
      cnt_r      <= 32'h0000_0000;
    end else begin
      o_asserted <= asserted_nxt;
      cnt_r      <= cnt_nxt;
    end
  end

endmodule

//--- core/sop_output_two.sv
// Sum-of-products condition logic, timeout and polarity for programmable output two.
// Assumes condition inputs are synchronous to i_clk and the register write port
// is driven by the serial configuration logic.
`timescale 1ns/1ps

// Operation
// - Output state comes from sum of products
// - Dual-product outputs provide two independent products
// - Single-product outputs, output two included, one product
// - Product true when all selected terms good
// - Output terms good deasserted; watchdog good unexpired
// - Output deasserts when any product true
// - Cleared enable bit removes its term
// - First register bits 0-5 select primary results
// - First register bits 6-7 select watchdogs
// - Second register bits 0-5 select secondary results
// - General inputs from second and third registers
// - Third register bits 2-7 select other outputs
// - Fourth register bit 0 selects output eight
// - Manual reset map bit 1 asserts output
// - Polarity register gives each output's active level
// - Stage and timeout fields in per-output register
// - Deassertion delayed by programmable timeout
module sop_output_two
  import sop_pkg::*;
#(
  parameter logic [31:0] TMO_CYC [TMO_N] = '{sop_us_to_cyc(TMO_US[0]), sop_us_to_cyc(TMO_US[1]),
                                             sop_us_to_cyc(TMO_US[2]), sop_us_to_cyc(TMO_US[3]),
                                             sop_us_to_cyc(TMO_US[4]), sop_us_to_cyc(TMO_US[5]),
                                             sop_us_to_cyc(TMO_US[6]), sop_us_to_cyc(TMO_US[7])}
)(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_cfg_wr,
  input  wire logic [7:0] i_cfg_addr,
  input  wire logic [7:0] i_cfg_wdata,
  input  wire logic [5:0] i_above_primary,
  input  wire logic [5:0] i_above_secondary,
  input  wire logic [3:0] i_gen_input_active,
  input  wire logic [1:0] i_watchdog_ok,
  input  wire logic [7:0] i_prog_output_asserted,
  input  wire logic       i_manual_reset_n,
  output logic [7:0]      o_cfg_rdata,
  output logic            o_prog_output_two_asserted,
  output logic            o_prog_output_two_level,
  output logic [3:0]      o_prog_output_two_stage
);

  // ---------------------------------------------------------------
  // Shared product and sum functions
  // ---------------------------------------------------------------
  // A term counts only where its enable is set; unselected terms pass
  function automatic logic sop_product(input logic [TERM_W-1:0] sel,
                                       input logic [TERM_W-1:0] good);
    sop_product = &(~sel | good);
  endfunction

  // Outputs with two products OR the second one in; single-product ones leave it out
  function automatic logic sop_sum(input logic p1, input logic p2, input logic dual);
    sop_sum = p1 | (dual & p2);
  endfunction

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] out2_primary_wdog_select_r;
  logic [7:0] out2_secondary_input_select_r;
  logic [7:0] out2_input_output_select_r;
  logic [7:0] out2_last_output_and_stage_r;
  logic [7:0] output_polarity_r;
  logic [7:0] manual_reset_output_map_r;
  logic [7:0] rdata_nxt;

  wire wr_12 = i_cfg_wr & (i_cfg_addr == OUT2_PRIMARY_WDOG_SELECT_ADDR);
  wire wr_13 = i_cfg_wr & (i_cfg_addr == OUT2_SECONDARY_INPUT_SELECT_ADDR);
  wire wr_14 = i_cfg_wr & (i_cfg_addr == OUT2_INPUT_OUTPUT_SELECT_ADDR);
  wire wr_15 = i_cfg_wr & (i_cfg_addr == OUT2_LAST_OUTPUT_AND_STAGE_ADDR);
  wire wr_3a = i_cfg_wr & (i_cfg_addr == OUTPUT_POLARITY_ADDR);
  wire wr_40 = i_cfg_wr & (i_cfg_addr == MANUAL_RESET_OUTPUT_MAP_ADDR);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out2_primary_wdog_select_r    <= CFG_RESET;
      out2_secondary_input_select_r <= CFG_RESET;
      out2_input_output_select_r    <= CFG_RESET;
      out2_last_output_and_stage_r  <= CFG_RESET;
      output_polarity_r             <= CFG_RESET;
      manual_reset_output_map_r     <= CFG_RESET;
    end else begin
      if (wr_12) out2_primary_wdog_select_r    <= i_cfg_wdata;
      if (wr_13) out2_secondary_input_select_r <= i_cfg_wdata;
      if (wr_14) out2_input_output_select_r    <= i_cfg_wdata;
      if (wr_15) out2_last_output_and_stage_r  <= i_cfg_wdata;
      if (wr_3a) output_polarity_r             <= i_cfg_wdata;
      if (wr_40) manual_reset_output_map_r     <= i_cfg_wdata;
    end
  end

  always_comb begin
    case (i_cfg_addr)
      OUT2_PRIMARY_WDOG_SELECT_ADDR:    rdata_nxt = out2_primary_wdog_select_r;
      OUT2_SECONDARY_INPUT_SELECT_ADDR: rdata_nxt = out2_secondary_input_select_r;
      OUT2_INPUT_OUTPUT_SELECT_ADDR:    rdata_nxt = out2_input_output_select_r;
      OUT2_LAST_OUTPUT_AND_STAGE_ADDR:  rdata_nxt = out2_last_output_and_stage_r;
      OUTPUT_POLARITY_ADDR:             rdata_nxt = output_polarity_r;
      MANUAL_RESET_OUTPUT_MAP_ADDR:     rdata_nxt = manual_reset_output_map_r;
      default:                          rdata_nxt = RDATA_UNMAPPED;
    endcase
  end

  // ---------------------------------------------------------------
  // Term selection and good states
  // ---------------------------------------------------------------
  logic [TERM_W-1:0] sel_w;
  logic [TERM_W-1:0] good_w;
  logic [6:0]        others_deasserted;

  // Outputs one, three..eight; output two never depends on itself
  assign others_deasserted = ~{i_prog_output_asserted[7:2], i_prog_output_asserted[0]};

  assign sel_w = {out2_last_output_and_stage_r[OUT8_DEP_BIT],
                  out2_input_output_select_r,
                  out2_secondary_input_select_r,
                  out2_primary_wdog_select_r};

  assign good_w = {others_deasserted,
                   ~i_gen_input_active,
                   i_above_secondary,
                   i_watchdog_ok,
                   i_above_primary};

  wire prod_w = sop_product(sel_w, good_w);
  wire sum_w  = sop_sum(prod_w, 1'b0, 1'b0);
  wire mr_w   = manual_reset_output_map_r[OUT2_MAP_BIT] & ~i_manual_reset_n;
  wire hold_w = ~sum_w | mr_w;

  // ---------------------------------------------------------------
  // Evaluation, timeout and polarity stages
  // ---------------------------------------------------------------
  logic        prod_r;
  logic        hold_r;
  logic        asserted_w;
  logic [31:0] tmo_cyc_w;

  assign tmo_cyc_w = TMO_CYC[out2_last_output_and_stage_r[TMO_LSB +: TMO_W]];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prod_r <= 1'b0;
      hold_r <= 1'b1;
    end else begin
      prod_r <= prod_w;
      hold_r <= hold_w;
    end
  end

  sop_deassert_timer u_timer (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_hold    (hold_r),
    .i_tmo_cyc (tmo_cyc_w),
    .o_asserted(asserted_w)
  );

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cfg_rdata                <= RDATA_UNMAPPED;
      o_prog_output_two_asserted <= 1'b1;
      o_prog_output_two_level    <= 1'b0;
      o_prog_output_two_stage    <= 4'h0;
    end else begin
      o_cfg_rdata                <= rdata_nxt;
      o_prog_output_two_asserted <= asserted_w;
      o_prog_output_two_level    <= ~(asserted_w ^ output_polarity_r[OUT2_POL_BIT]);
      o_prog_output_two_stage    <= out2_last_output_and_stage_r[STAGE_LSB +: STAGE_W];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_empty_true;
    (sel_w == '0) |=> prod_r;
  endproperty
  a_empty_true: assert property (p_empty_true) else $error("empty product not true");

  property p_primary;
    out2_primary_wdog_select_r[0] && !i_above_primary[0] |=> !prod_r;
  endproperty
  a_primary: assert property (p_primary) else $error("primary term ignored");

  property p_watchdog;
    out2_primary_wdog_select_r[7] && !i_watchdog_ok[1] |=> !prod_r;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog term ignored");

  property p_secondary;
    out2_secondary_input_select_r[5] && !i_above_secondary[5] |=> !prod_r;
  endproperty
  a_secondary: assert property (p_secondary) else $error("secondary term ignored");

  property p_gen_input;
    out2_input_output_select_r[1] && i_gen_input_active[3] |=> !prod_r;
  endproperty
  a_gen_input: assert property (p_gen_input) else $error("input four term ignored");

  property p_other_output;
    out2_input_output_select_r[2] && i_prog_output_asserted[0] |=> !prod_r;
  endproperty
  a_other_output: assert property (p_other_output) else $error("output one term ignored");

  property p_output_eight;
    out2_last_output_and_stage_r[0] && i_prog_output_asserted[7] |=> !prod_r;
  endproperty
  a_output_eight: assert property (p_output_eight) else $error("output eight ignored");

  property p_manual_reset;
    manual_reset_output_map_r[1] && !i_manual_reset_n |-> ##3 o_prog_output_two_asserted;
  endproperty
  a_manual_reset: assert property (p_manual_reset) else $error("manual reset missed");

  property p_polarity;
    ##1 o_prog_output_two_level == ($past(asserted_w) ~^ $past(output_polarity_r[1]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("wrong output level");

  property p_assert_fast;
    !prod_r |=> ##1 o_prog_output_two_asserted;
  endproperty
  a_assert_fast: assert property (p_assert_fast) else $error("assertion delayed");

  property p_no_early_release;
    $rose(prod_r) && !$past(mr_w) && tmo_cyc_w > 32'h1 |=> asserted_w;
  endproperty
  a_no_early_release: assert property (p_no_early_release) else $error("released early");

  property p_primary_six;
    out2_primary_wdog_select_r[5] && !i_above_primary[5] |=> !prod_r;
  endproperty
  a_primary_six: assert property (p_primary_six) else $error("primary six ignored");

  property p_watchdog_one;
    out2_primary_wdog_select_r[6] && !i_watchdog_ok[0] |=> !prod_r;
  endproperty
  a_watchdog_one: assert property (p_watchdog_one) else $error("expired watchdog passed");

  property p_secondary_one;
    out2_secondary_input_select_r[0] && !i_above_secondary[0] |=> !prod_r;
  endproperty
  a_secondary_one: assert property (p_secondary_one) else $error("secondary one ignored");

  property p_gen_input_one;
    out2_secondary_input_select_r[6] && i_gen_input_active[0] |=> !prod_r;
  endproperty
  a_gen_input_one: assert property (p_gen_input_one) else $error("input one ignored");

  property p_output_three;
    out2_input_output_select_r[3] && i_prog_output_asserted[2] |=> !prod_r;
  endproperty
  a_output_three: assert property (p_output_three) else $error("output three ignored");

  property p_output_seven;
    out2_input_output_select_r[7] && i_prog_output_asserted[6] |=> !prod_r;
  endproperty
  a_output_seven: assert property (p_output_seven) else $error("asserted output passed");

  property p_all_good;
    (&i_above_primary) && (&i_above_secondary) && (i_gen_input_active == 4'h0) &&
      (&i_watchdog_ok) && !i_prog_output_asserted[0] &&
      (i_prog_output_asserted[7:2] == 6'h00) |=> prod_r;
  endproperty
  a_all_good: assert property (p_all_good) else $error("good terms gave false");

  property p_mr_ignored;
    !manual_reset_output_map_r[OUT2_MAP_BIT] && prod_w |=> !hold_r;
  endproperty
  a_mr_ignored: assert property (p_mr_ignored) else $error("unmapped manual reset held");

  property p_release_true;
    prod_w && !mr_w |=> !hold_r;
  endproperty
  a_release_true: assert property (p_release_true) else $error("true product held");

  property p_hold_false;
    !prod_w |=> hold_r;
  endproperty
  a_hold_false: assert property (p_hold_false) else $error("false product released");

  property p_stage_write;
    wr_15 |=> ##1 o_prog_output_two_stage == $past(i_cfg_wdata[STAGE_LSB +: STAGE_W], 2);
  endproperty
  a_stage_write: assert property (p_stage_write) else $error("stage field wrong");

  c_product_true:  cover property ($rose(prod_r));
  c_released:      cover property ($fell(o_prog_output_two_asserted));
  c_manual_reset:  cover property (mr_w ##1 hold_r);
  c_active_high:   cover property (output_polarity_r[1] && o_prog_output_two_level);
  c_long_timeout:  cover property ((out2_last_output_and_stage_r[TMO_LSB +: TMO_W] == 3'h7) &&
                                   $fell(asserted_w));

endmodule

//--- bench/sop_supply_model.sv
// Far-side model: supplies, general inputs, watchdogs and the other outputs.
// Assumes the bench gives one fault bit per term, in enable-register bit order.
`timescale 1ns/1ps
module sop_supply_model (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [24:0] i_bad,
  input  wire logic        i_mr_press,
  output logic [5:0]       o_above_primary,
  output logic [5:0]       o_above_secondary,
  output logic [3:0]       o_gen_input_active,
  output logic [1:0]       o_watchdog_ok,
  output logic [7:0]       o_prog_output_asserted,
  output logic             o_manual_reset_n
);
  // ---------------------------------------------------------------
  // Condition sources, registered like real synchronised inputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_above_primary        <= 6'h3F;
      o_above_secondary      <= 6'h3F;
      o_gen_input_active     <= 4'h0;
      o_watchdog_ok          <= 2'h3;
      o_prog_output_asserted <= 8'h02;
      o_manual_reset_n       <= 1'b1;
    end else begin
      o_above_primary        <= ~i_bad[5:0];
      o_watchdog_ok          <= ~i_bad[7:6];
      o_above_secondary      <= ~i_bad[13:8];
      o_gen_input_active     <= i_bad[17:14];
      // Own bit held asserted: the block must ignore it
      o_prog_output_asserted <= {i_bad[24:19], 1'b1, i_bad[18]};
      o_manual_reset_n       <= ~i_mr_press;
    end
  end
endmodule

//--- bench/tb.sv
// Self-checking bench for output two's condition logic.
// Assumes short timeouts through TMO_CYC and the supply model as condition source.
`timescale 1ns/1ps
module tb
  import sop_pkg::*;
;
  localparam logic [31:0] TMO_T [TMO_N] = '{2, 3, 4, 5, 6, 7, 8, 9};
  logic        clk, nrst, wr, mr, asr, lvl;
  logic [7:0]  addr, wdata, rdata, po;
  logic [24:0] bad;
  logic [5:0]  ap, asec;
  logic [3:0]  gi, stage;
  logic [1:0]  wd;
  logic        mrn;
  int          err_count, compares;
  logic [7:0]  regs [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h3A, 8'h40};

  sop_output_two #(.TMO_CYC(TMO_T)) i_sop_output_two (
    .i_clk(clk), .i_nrst(nrst), .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
    .i_above_primary(ap), .i_above_secondary(asec), .i_gen_input_active(gi),
    .i_watchdog_ok(wd), .i_prog_output_asserted(po), .i_manual_reset_n(mrn),
    .o_cfg_rdata(rdata), .o_prog_output_two_asserted(asr), .o_prog_output_two_level(lvl),
    .o_prog_output_two_stage(stage));

  sop_supply_model i_sop_supply_model (
    .i_clk(clk), .i_nrst(nrst), .i_bad(bad), .i_mr_press(mr), .o_above_primary(ap),
    .o_above_secondary(asec), .o_gen_input_active(gi), .o_watchdog_ok(wd),
    .o_prog_output_asserted(po), .o_manual_reset_n(mrn));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1 d = rdata;
  endtask

  task automatic set_cond(input logic [24:0] b, input logic m);
    @(posedge clk);
    bad <= b;
    mr  <= m;
  endtask

  // Lets the condition pipeline settle, then waits a bounded time for exp
  task automatic wait_out(input logic exp, output int n);
    n = 0;
    repeat (4) @(posedge clk);
    #1;
    while (asr !== exp && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    #1;
    chk("asserted after reset", 1, asr);
    chk("stage after reset", 0, stage);
    for (int i = 0; i < 6; i++) begin
      rd_reg(regs[i], d);
      chk("reset value", 0, d);
    end
    $display("done t_reset");
  endtask

  task automatic t_regs;
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      wr_reg(regs[i], 8'h5A ^ 8'(i));
      rd_reg(regs[i], d);
      chk("readback", 8'h5A ^ 8'(i), d);
      wr_reg(regs[i], 8'h00);
    end
    wr_reg(8'h16, 8'hFF);
    rd_reg(8'h16, d);
    chk("unmapped read", 0, d);
    wr_reg(8'h15, 8'h1E);
    repeat (4) @(posedge clk);
    #1 chk("stage field", 4'hF, stage);
    wr_reg(8'h15, 8'h00);
    $display("done t_regs");
  endtask

  task automatic t_terms;
    int n;
    logic [24:0] c;
    set_cond('1, 1'b0);
    wait_out(1'b0, n);
    chk("empty product", 0, asr);
    for (int k = 0; k < 25; k++) begin
      c = 25'(1) << k;
      wr_reg(8'h12, c[7:0]);
      wr_reg(8'h13, c[15:8]);
      wr_reg(8'h14, c[23:16]);
      wr_reg(8'h15, {7'h0, c[24]});
      set_cond(~c, 1'b0);
      wait_out(1'b0, n);
      chk("term good releases", 0, asr);
      set_cond(c, 1'b0);
      wait_out(1'b1, n);
      chk("term bad asserts", 1, asr);
    end
    wr_reg(8'h15, 8'h00);
    wr_reg(8'h14, 8'h00);
    wr_reg(8'h13, 8'h00);
    wr_reg(8'h12, 8'h03);
    set_cond(25'h2, 1'b0);
    wait_out(1'b1, n);
    chk("one of two bad", 1, asr);
    $display("done t_terms");
  endtask

  task automatic t_mr_pol;
    int n;
    wr_reg(8'h12, 8'h00);
    wr_reg(8'h40, 8'h01);
    set_cond('0, 1'b1);
    repeat (10) @(posedge clk);
    #1 chk("other map bit", 0, asr);
    wr_reg(8'h40, 8'h02);
    wait_out(1'b1, n);
    chk("manual reset asserts", 1, asr);
    wr_reg(8'h3A, 8'h02);
    repeat (4) @(posedge clk);
    #1 chk("level high active", 1, lvl);
    wr_reg(8'h3A, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk("level low active", 0, lvl);
    set_cond('0, 1'b0);
    wait_out(1'b0, n);
    chk("release level", 1, lvl);
    wr_reg(8'h40, 8'h00);
    $display("done t_mr_pol");
  endtask

  task automatic t_tmo;
    int n, n0;
    wr_reg(8'h12, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr_reg(8'h15, {3'(k), 5'h00});
      set_cond(25'h1, 1'b0);
      wait_out(1'b1, n);
      chk("assert span", 0, n);
      set_cond('0, 1'b0);
      wait_out(1'b0, n);
      if (k == 0) n0 = n;
      chk("timeout span", TMO_T[k] - TMO_T[0], 32'(n - n0));
    end
    $display("done t_tmo");
  endtask

  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    bad = '0;
    mr = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_terms();
    t_mr_pol();
    t_tmo();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
